/* File: src/adfw_pkg.sv */
/*
 * Constants for the alternate divider and frequency word register block:
 * register addresses, field positions, reset values and divider decoding.
 * Assumes byte-wide registers reached by a byte address from the serial engine.
 */
package adfw_pkg;

    // ==========================================================
    // register addresses
    localparam logic [7:0] ADDR_HS_N1HI   = 8'h0D;
    localparam logic [7:0] ADDR_N1LO_WTOP = 8'h0E;
    localparam logic [7:0] ADDR_W31_24    = 8'h0F;
    localparam logic [7:0] ADDR_W23_16    = 8'h10;

    // ==========================================================
    // field positions
    localparam int HS_MSB   = 7;
    localparam int HS_LSB   = 5;
    localparam int N1HI_MSB = 4;
    localparam int N1HI_LSB = 0;
    localparam int N1LO_MSB = 7;
    localparam int N1LO_LSB = 6;
    localparam int WTOP_MSB = 5;
    localparam int WTOP_LSB = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] REG_RST    = 8'h00;
    localparam logic [7:0] RATIO_NONE = 8'h00;
    localparam logic [7:0] ACT_HS_RST = 8'h04;
    localparam logic [7:0] ACT_N1_RST = 8'h01;
    localparam logic [21:0] ACT_WORD_RST = 22'h000000;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // ==========================================================
    // divider decoding
    function automatic logic [7:0] hs_ratio(input logic [2:0] code);
        logic [7:0] r;
        r = RATIO_NONE;
        case (code)
            3'h0: r = 8'h04;
            3'h1: r = 8'h05;
            3'h2: r = 8'h06;
            3'h3: r = 8'h07;
            3'h5: r = 8'h09;
            3'h7: r = 8'h0B;
            default: r = RATIO_NONE;
        endcase
        return r;
    endfunction

    // code is ratio minus one; odd ratios above one round up to even
    function automatic logic [7:0] n1_ratio(input logic [6:0] code);
        logic [7:0] r;
        r = {1'b0, code} + 8'h01;
        if (r[0] && (r != 8'h01)) begin
            r = r + 8'h01;
        end
        return r;
    endfunction

endpackage

/* File: src/adfw_div_if.sv */
/*
 * Ratio and tick bundle between the register block and one divider stage.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/10ps
interface adfw_div_if #(
    parameter int W = 8
);
    logic [W-1:0] ratio;
    logic         in_tick;
    logic         out_tick;

    modport div (input ratio, input in_tick, output out_tick);
    modport ctl (output ratio, output in_tick, input out_tick);
endinterface

/* File: src/adfw_divider.sv */
/*
 * One counting divider stage: emits one tick for every ratio input ticks.
 * Assumes the ratio is held steady by the controller between applies.
 */
`timescale 1ns/10ps
module adfw_divider #(
    parameter int W = 8
) (
    input  wire logic sys_clk,   // system clock
    input  wire logic sys_rst,   // synchronous reset, high
    adfw_div_if.div   dv         // ratio in, ticks in and out
);

    // ==========================================================
    // counter
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         out_q;
    wire  [W:0]   cnt_inc = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};
    wire          last    = (cnt_inc >= {1'b0, dv.ratio});
    wire          wrap    = dv.in_tick && last;

    assign cnt_d       = !dv.in_tick ? cnt_q : (last ? '0 : cnt_inc[W-1:0]);
    assign dv.out_tick = out_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= wrap;
        end
    end

    // ==========================================================
    // checks
    AST_DIV_WRAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrap |=> (out_q && (cnt_q == '0)))
        else $error("divider did not wrap on its last input tick");

    AST_DIV_QUIET: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !dv.in_tick |=> (!out_q && $stable(cnt_q)))
        else $error("divider moved without an input tick");

endmodule

/* File: src/adfw_regs.sv */
/*
 * Alternate divider and frequency word registers with the divider chain they
 * steer. Shadow registers take host writes; the active settings load only when
 * an apply is pending and the oscillator hold is released.
 * Assumes a serial engine on sys_clk that gives byte address, read and write
 * strobes, and a control register outside that gives the hold level and the
 * apply set pulse.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - High-speed divider counts oscillator ticks; codes give 4,5,6,7,9,11; two unused.
// - Output divider code: top five bits in first register, low two in next.
// - Odd output ratios above one are rounded up to the next even ratio.
// - Output divider code is ratio minus one: zero gives one, all ones 128.
// - Frequency word top six bits sit low in second register, next bytes below.
// - Host holds the oscillator before changing configuration; active settings stay frozen.
// - Host sets apply flag; device clears it itself once settings are applied.
module adfw_regs (
    input  wire logic        sys_clk,                          // system clock
    input  wire logic        sys_rst,                          // sync reset, high
    input  wire logic [7:0]  reg_addr,                         // register byte address
    input  wire logic        reg_wr,                           // write strobe
    input  wire logic [7:0]  reg_wdata,                        // write data
    input  wire logic        reg_rd,                           // read strobe
    output logic      [7:0]  reg_rdata,                        // read data, next cycle
    input  wire logic        oscillator_hold,                  // hold level
    input  wire logic        apply_new_config_set,             // apply request pulse
    output logic             apply_new_config,                 // apply pending flag
    input  wire logic        controlled_oscillator_tick,       // oscillator tick
    output logic      [7:0]  alt_high_speed_ratio,             // active hs ratio
    output logic      [7:0]  alt_output_ratio,                 // active output ratio
    output logic      [21:0] alt_reference_frequency_word_top, // active word 37:16
    output logic             hs_clock_tick,                    // hs divider tick
    output logic             output_clock                      // output divider tick
);

    // ==========================================================
    // shadow registers
    logic [7:0] alt_hs_div_and_out_div_high_q;
    logic [7:0] alt_out_div_low_and_freq_word_top_q;
    logic [7:0] alt_freq_word_byte_31_24_q;
    logic [7:0] alt_freq_word_byte_23_16_q;
    logic [7:0] rdata_q;

    wire sel_div_high = (reg_addr == adfw_pkg::ADDR_HS_N1HI);
    wire sel_div_low  = (reg_addr == adfw_pkg::ADDR_N1LO_WTOP);
    wire sel_word_hi  = (reg_addr == adfw_pkg::ADDR_W31_24);
    wire sel_word_lo  = (reg_addr == adfw_pkg::ADDR_W23_16);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            alt_hs_div_and_out_div_high_q       <= adfw_pkg::REG_RST;
            alt_out_div_low_and_freq_word_top_q <= adfw_pkg::REG_RST;
            alt_freq_word_byte_31_24_q          <= adfw_pkg::REG_RST;
            alt_freq_word_byte_23_16_q          <= adfw_pkg::REG_RST;
        end else if (reg_wr) begin
            if (sel_div_high) begin
                alt_hs_div_and_out_div_high_q <= reg_wdata;
            end
            if (sel_div_low) begin
                alt_out_div_low_and_freq_word_top_q <= reg_wdata;
            end
            if (sel_word_hi) begin
                alt_freq_word_byte_31_24_q <= reg_wdata;
            end
            if (sel_word_lo) begin
                alt_freq_word_byte_23_16_q <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // field extraction and decode
    wire [2:0]  hs_code = alt_hs_div_and_out_div_high_q[adfw_pkg::HS_MSB:adfw_pkg::HS_LSB];
    wire [4:0]  od_hi   = alt_hs_div_and_out_div_high_q[adfw_pkg::N1HI_MSB:
                                                        adfw_pkg::N1HI_LSB];
    wire [1:0]  od_lo   = alt_out_div_low_and_freq_word_top_q[adfw_pkg::N1LO_MSB:
                                                              adfw_pkg::N1LO_LSB];
    wire [5:0]  wtop    = alt_out_div_low_and_freq_word_top_q[adfw_pkg::WTOP_MSB:
                                                              adfw_pkg::WTOP_LSB];
    wire [6:0]  n1_code = {od_hi, od_lo};
    wire [21:0] word_sh = {wtop, alt_freq_word_byte_31_24_q, alt_freq_word_byte_23_16_q};
    wire [7:0]  hs_dec  = adfw_pkg::hs_ratio(hs_code);
    wire [7:0]  n1_dec  = adfw_pkg::n1_ratio(n1_code);
    wire        hs_ok   = (hs_dec != adfw_pkg::RATIO_NONE);

    wire [7:0] rd_mux = sel_div_high ? alt_hs_div_and_out_div_high_q :
                        sel_div_low  ? alt_out_div_low_and_freq_word_top_q :
                        sel_word_hi  ? alt_freq_word_byte_31_24_q :
                        sel_word_lo  ? alt_freq_word_byte_23_16_q : adfw_pkg::RDATA_NONE;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= adfw_pkg::RDATA_NONE;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = rdata_q;

    // ==========================================================
    // apply handshake and active settings
    logic        pend_q;
    logic [7:0]  act_hs_q;
    logic [7:0]  act_n1_q;
    logic [21:0] act_word_q;

    wire do_apply = pend_q && !oscillator_hold;
    // a new request in the apply cycle keeps the flag set
    wire pend_d   = apply_new_config_set || (pend_q && !do_apply);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            act_hs_q   <= adfw_pkg::ACT_HS_RST;
            act_n1_q   <= adfw_pkg::ACT_N1_RST;
            act_word_q <= adfw_pkg::ACT_WORD_RST;
        end else if (do_apply) begin
            // an unused hs code keeps the previous ratio
            act_hs_q   <= hs_ok ? hs_dec : act_hs_q;
            act_n1_q   <= n1_dec;
            act_word_q <= word_sh;
        end
    end

    assign apply_new_config                = pend_q;
    assign alt_high_speed_ratio            = act_hs_q;
    assign alt_output_ratio                = act_n1_q;
    assign alt_reference_frequency_word_top = act_word_q;

    // ==========================================================
    // divider chain
    adfw_div_if #(.W(8)) hs_if ();
    adfw_div_if #(.W(8)) n1_if ();

    assign hs_if.ratio   = act_hs_q;
    assign hs_if.in_tick = controlled_oscillator_tick;
    assign n1_if.ratio   = act_n1_q;
    assign n1_if.in_tick = hs_if.out_tick;
    assign hs_clock_tick = hs_if.out_tick;
    assign output_clock  = n1_if.out_tick;

    adfw_divider #(.W(8)) u_hs_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .dv      (hs_if)
    );

    adfw_divider #(.W(8)) u_n1_div (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .dv      (n1_if)
    );

    // ==========================================================
    // checks
    sequence seq_apply;
        pend_q && !oscillator_hold;
    endsequence

    sequence seq_loaded;
        (act_n1_q == $past(n1_dec)) && (act_word_q == $past(word_sh));
    endsequence

    AST_HS_LEGAL: assert property (@(posedge sys_clk) disable iff (sys_rst)
        act_hs_q inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0B})
        else $error("active hs ratio outside the legal set");

    AST_HS_APPLY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (seq_apply and hs_ok) |=> (act_hs_q == $past(hs_dec)))
        else $error("legal hs code not loaded on apply");

    AST_HS_KEEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (seq_apply and !hs_ok) |=> $stable(act_hs_q))
        else $error("unused hs code changed the active ratio");

    AST_N1_EVEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (act_n1_q == 8'h01) || (!act_n1_q[0] && (act_n1_q != 8'h00)))
        else $error("active output ratio is odd and above one");

    AST_N1_MAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ((n1_code == 7'h00) -> (n1_dec == 8'h01)) &&
        ((n1_code == 7'h7F) -> (n1_dec == 8'h80)) &&
        ((n1_code == 7'h09) -> (n1_dec == 8'h0A)))
        else $error("output divider code decoded wrongly");

    AST_READ_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && sel_div_high && !reg_wr) |=> (reg_rdata[4:0] == $past(n1_code[6:2])))
        else $error("first register read lost the upper output divider bits");

    AST_READ_SECOND: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && sel_div_low && !reg_wr) |=>
            (reg_rdata == {$past(n1_code[1:0]), $past(word_sh[21:16])}))
        else $error("second register read lost output divider or word bits");

    AST_READ_WORD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && (sel_word_hi || sel_word_lo) && !reg_wr) |=>
            (reg_rdata == ($past(sel_word_hi) ? $past(word_sh[15:8]) : $past(word_sh[7:0]))))
        else $error("word byte read back wrongly");

    AST_APPLY_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        seq_apply |=> seq_loaded)
        else $error("apply did not load the shadow settings");

    AST_HOLD_FREEZE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        oscillator_hold |=> ($stable(act_hs_q) && $stable(act_n1_q) && $stable(act_word_q)))
        else $error("active settings changed during hold");

    AST_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (seq_apply and !apply_new_config_set) |=> !apply_new_config)
        else $error("apply flag not cleared after apply");

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (sys_rst)
        apply_new_config_set |=> apply_new_config)
        else $error("apply request lost");

    AST_PEND_WAIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pend_q && oscillator_hold && !apply_new_config_set) |=> pend_q)
        else $error("apply flag dropped while held");

endmodule

/* File: sim/adfw_osc_model.sv */
/*
 * Oscillator tick source standing in front of the divider chain.
 * Assumes sys_clk is the only clock; ticks change just after rising edges.
 */
`timescale 1ns/10ps
module adfw_osc_model (
    input  wire logic sys_clk,  // system clock
    input  wire logic sys_rst,  // sync reset, high
    input  wire logic run,      // tick source enabled
    input  wire logic slow,     // tick every other cycle
    output logic      tick      // oscillator tick
);
    // ==========================================================
    // tick pattern
    logic phase_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_q <= 1'b0;
            tick    <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            tick    <= run & (~slow | phase_q);
        end
    end
endmodule

/* File: sim/alt_divider_freq_word_regs_bench.sv */
/*
 * Bench for adfw_regs: register access, hold and apply, divider decoding and
 * divider tick spacing. Assumes adfw_osc_model drives the oscillator tick.
 */
`timescale 1ns/10ps
module alt_divider_freq_word_regs_bench;
    // ==========================================================
    // signals
    logic        sys_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic        hold      = 1'b0;
    logic        set       = 1'b0;
    logic        flag;
    logic        tick;
    logic        run       = 1'b0;
    logic        slow      = 1'b0;
    logic [7:0]  hs_r;
    logic [7:0]  out_r;
    logic [21:0] word;
    logic        hs_t;
    logic        out_t;
    int          failures  = 0;
    int          samples_checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    adfw_osc_model osc (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run), .slow(slow),
                        .tick(tick));
    adfw_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .oscillator_hold(hold), .apply_new_config_set(set), .apply_new_config(flag),
        .controlled_oscillator_tick(tick), .alt_high_speed_ratio(hs_r),
        .alt_output_ratio(out_r), .alt_reference_frequency_word_top(word),
        .hs_clock_tick(hs_t), .output_clock(out_t));

    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    task automatic load_cfg(input logic [2:0] hs, input logic [6:0] n1, input logic [21:0] w);
        wr(adfw_pkg::ADDR_HS_N1HI, {hs, n1[6:2]});
        wr(adfw_pkg::ADDR_N1LO_WTOP, {n1[1:0], w[21:16]});
        wr(adfw_pkg::ADDR_W31_24, w[15:8]);
        wr(adfw_pkg::ADDR_W23_16, w[7:0]);
        @(posedge sys_clk);
        set <= 1'b1;
        @(posedge sys_clk);
        set <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // cycles between the second and third pulse of the chosen tick
    task automatic gap(input logic sel, output int n);
        int k;
        n = 0;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                #1;
                n++;
            end while (((sel ? out_t : hs_t) !== 1'b1) && n < 400);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog
    initial begin
        #(25 * 20000);
        failures++;
        report_and_stop();
    end

    // ==========================================================
    // tests
    initial begin
        logic [7:0] hs_exp [8];
        logic [6:0] n1_code [6];
        logic [7:0] n1_exp [6];
        logic [7:0] prev;
        int         i;
        int         n;
        hs_exp  = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h00, 8'h09, 8'h00, 8'h0B};
        n1_code = '{7'h00, 7'h01, 7'h02, 7'h09, 7'h7E, 7'h7F};
        n1_exp  = '{8'h01, 8'h02, 8'h04, 8'h0A, 8'h80, 8'h80};
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i++) rdchk(8'(8'h0D + i), adfw_pkg::REG_RST);
        #1;
        check(hs_r, adfw_pkg::ACT_HS_RST);
        check(out_r, adfw_pkg::ACT_N1_RST);
        check(word, adfw_pkg::ACT_WORD_RST);
        // readback, unmapped place ignored
        wr(8'h0D, 8'hA5);
        wr(8'h0E, 8'h5A);
        wr(8'h0F, 8'hC3);
        wr(8'h10, 8'h3C);
        wr(8'h11, 8'hFF);
        rdchk(8'h0D, 8'hA5);
        rdchk(8'h0E, 8'h5A);
        rdchk(8'h0F, 8'hC3);
        rdchk(8'h10, 8'h3C);
        rdchk(8'h11, 8'h00);
        check(hs_r, 8'h04);
        // held configuration, applied on release
        @(posedge sys_clk);
        hold <= 1'b1;
        load_cfg(3'h1, 7'h09, 22'h2A5C3E);
        check(flag, 1'b1);
        check(hs_r, 8'h04);
        @(posedge sys_clk);
        hold <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(flag, 1'b0);
        check(hs_r, 8'h05);
        check(out_r, 8'h0A);
        check(word, 22'h2A5C3E);
        // every high-speed code, unused ones keep the last ratio
        prev = 8'h05;
        for (i = 0; i < 8; i++) begin
            load_cfg(i[2:0], 7'h01, 22'h000000);
            if (hs_exp[i] !== 8'h00) prev = hs_exp[i];
            check(hs_r, prev);
        end
        for (i = 0; i < 6; i++) begin
            load_cfg(3'h0, n1_code[i], 22'h3FFFFF);
            check(out_r, n1_exp[i]);
            check(flag, 1'b0);
        end
        // request in the apply cycle keeps the flag set
        @(posedge sys_clk);
        set <= 1'b1;
        repeat (2) @(posedge sys_clk);
        set <= 1'b0;
        #1;
        check(flag, 1'b1);
        @(posedge sys_clk);
        #1;
        check(flag, 1'b0);
        // divider chain spacing
        load_cfg(3'h0, 7'h01, 22'h000000);
        @(posedge sys_clk);
        run <= 1'b1;
        gap(1'b0, n);
        check(n, 4);
        gap(1'b1, n);
        check(n, 8);
        @(posedge sys_clk);
        slow <= 1'b1;
        gap(1'b0, n);
        check(n, 8);
        @(posedge sys_clk);
        slow <= 1'b0;
        load_cfg(3'h5, 7'h00, 22'h000000);
        gap(1'b0, n);
        check(n, 9);
        gap(1'b1, n);
        check(n, 9);
        report_and_stop();
    end
endmodule
